// [verilog/cis_pkg.sv]
package cis_pkg;
	// Instruction word and address widths.
	localparam int CIS_PC_W = 13;
	localparam int CIS_OP_W = 14;
	localparam int CIS_FA_W = 7;
	localparam int CIS_NUM_SRC = 14;
	localparam int CIS_NUM_PERIPH = CIS_NUM_SRC - 3;
	// Interrupt vector and reset vector.
	localparam logic [12:0] CIS_IRQ_VECTOR = 13'h0004;
	localparam logic [12:0] CIS_RESET_VECTOR = 13'h0000;
	// Control register bit positions.
	localparam int CIS_GIE_BIT = 7;
	localparam int CIS_PERIPHERAL_IRQ_MASTER_ENABLE_BIT = 6;
	localparam int CIS_T0IE_BIT = 5;
	localparam int CIS_INTE_BIT = 4;
	localparam int CIS_RBIE_BIT = 3;
	localparam int CIS_T0IF_BIT = 2;
	localparam int CIS_INTF_BIT = 1;
	localparam int CIS_RBIF_BIT = 0;
	localparam logic [7:0] CIS_CTRL_RESET = 8'h00;
	localparam logic [7:0] CIS_ZERO8 = 8'h00;
	localparam logic [7:0] CIS_ONE8 = 8'h01;
	// Call target layout.
	localparam int CIS_CALL_LO_W = 11;
	localparam int CIS_LATCH_HI = 4;
	localparam int CIS_LATCH_LO = 3;
	// Opcode encodings (whole 14-bit words, then high-bit prefixes of 7, 6 and 3 bits).
	localparam logic [13:0] CIS_OPC_RETURN = 14'h0008;
	localparam logic [13:0] CIS_OPC_RETURN_FROM_IRQ_OP = 14'h0009;
	localparam logic [13:0] CIS_OPC_SLEEP = 14'h0063;
	localparam logic [13:0] CIS_OPC_WATCHDOG_CLEAR_OP = 14'h0064;
	localparam logic [6:0] CIS_OPH_CLR = 7'h03;
	localparam logic [5:0] CIS_OPH_FILE_INVERT_OP = 6'h09;
	localparam logic [5:0] CIS_OPH_FILE_DECREMENT_OP = 6'h03;
	localparam logic [5:0] CIS_OPH_RRF = 6'h0C;
	localparam logic [5:0] CIS_OPH_RLF = 6'h0D;
	localparam logic [2:0] CIS_OPH_CALL = 3'h4;
	// Core sequencer states.
	typedef enum logic [1:0] {CIS_FETCH, CIS_SECOND, CIS_IRQ_SYNC, CIS_HALT} cis_state_t;
endpackage

// [verilog/cis_sync_bank.sv]
`timescale 1ns/1ps
module cis_sync_bank
	import cis_pkg::*;
#(
	parameter int WIDTH = 3
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// Two-stage synchroniser per bit; only the second stage is visible.
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					meta_reg[i] <= 1'b0;
					sync_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= async_in[i];
					sync_reg[i] <= meta_reg[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_reg;
endmodule // cis_sync_bank

// [verilog/cis_core.sv]
`timescale 1ns/1ps
module cis_core
	import cis_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [7:0] file_rdata,
	input wire logic [12:0] stack_top,
	input wire logic [7:0] pc_high_latch,
	input wire logic carry_in,
	input wire logic edge_irq_pin,
	input wire logic port_change_evt,
	input wire logic timer_zero_ovf,
	input wire logic [10:0] periph_evt,
	input wire logic wake_evt,
	input wire logic ctrl_we,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [10:0] periph_flag_clr,
	input wire logic [10:0] periph_enable_wdata,
	input wire logic periph_enable_we,
	output logic [12:0] pc,
	output logic fetch_req,
	output logic [6:0] file_addr,
	output logic file_we,
	output logic [7:0] file_wdata,
	output logic stack_push,
	output logic stack_pop,
	output logic [12:0] stack_push_data,
	output logic [7:0] w_reg_out,
	output logic zero_flag,
	output logic carry_flag,
	output logic zero_we,
	output logic carry_we,
	output logic timeout_status,
	output logic powerdown_status,
	output logic watchdog_clear,
	output logic asleep,
	output logic [7:0] irq_control_reg,
	output logic [10:0] periph_flags,
	output logic [10:0] periph_enables
);
	logic [2:0] ext_sync;
	logic edge_prev_reg;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [10:0] pflag_reg, pflag_next;
	logic [10:0] pen_reg, pen_next;
	cis_state_t state_reg, state_next;
	logic [12:0] pc_reg, pc_next;
	logic [12:0] call_tgt_reg, call_tgt_next;
	logic [7:0] w_reg, w_next;
	logic z_reg, z_next, c_reg, c_next;
	logic to_reg, to_next, pd_reg, pd_next;
	logic [7:0] fdata_reg, fdata_next;
	logic [6:0] faddr_reg, faddr_next;
	logic fwe_reg, fwe_next, zwe_reg, zwe_next, cwe_reg, cwe_next;
	logic push_reg, push_next, pop_reg, pop_next, wdc_reg, wdc_next;
	logic [12:0] pdata_reg, pdata_next;
	logic irq_pending, periph_pending, edge_evt;
	logic [7:0] res;
	logic dest_file;

	// Pin-side events cross into the core clock before anything looks at them.
	cis_sync_bank #(.WIDTH(3)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in({edge_irq_pin, port_change_evt, timer_zero_ovf}),
		.sync_out(ext_sync)
	);

	// Rising edge of the synchronised pin raises the pin flag.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			edge_prev_reg <= 1'b0;
		end else begin
			edge_prev_reg <= ext_sync[2];
		end
	end
	assign edge_evt = ext_sync[2] & ~edge_prev_reg;

	// Request gating; peripheral sources also need the master enable.
	assign periph_pending = ctrl_reg[CIS_PERIPHERAL_IRQ_MASTER_ENABLE_BIT] & |(pflag_reg & pen_reg);
	assign irq_pending = ctrl_reg[CIS_GIE_BIT] & (periph_pending |
		(ctrl_reg[CIS_T0IE_BIT] & ctrl_reg[CIS_T0IF_BIT]) |
		(ctrl_reg[CIS_INTE_BIT] & ctrl_reg[CIS_INTF_BIT]) |
		(ctrl_reg[CIS_RBIE_BIT] & ctrl_reg[CIS_RBIF_BIT]));

	// Decode and sequencing; software writes lose against hardware sets in the same cycle.
	always_comb begin
		ctrl_next = ctrl_reg;
		pflag_next = pflag_reg & ~periph_flag_clr;
		pen_next = pen_reg;
		state_next = state_reg;
		pc_next = pc_reg;
		call_tgt_next = call_tgt_reg;
		w_next = w_reg;
		z_next = z_reg;
		c_next = c_reg;
		to_next = to_reg;
		pd_next = pd_reg;
		fdata_next = fdata_reg;
		faddr_next = instr_word[6:0];
		fwe_next = 1'b0;
		zwe_next = 1'b0;
		cwe_next = 1'b0;
		push_next = 1'b0;
		pop_next = 1'b0;
		wdc_next = 1'b0;
		pdata_next = pdata_reg;
		res = CIS_ZERO8;
		dest_file = instr_word[7];
		if (ctrl_we) begin
			ctrl_next = ctrl_wdata;
		end
		if (periph_enable_we) begin
			pen_next = periph_enable_wdata;
		end
		// Flags set on events irrespective of masks. is software's duty.
		if (ext_sync[0]) ctrl_next[CIS_T0IF_BIT] = 1'b1;
		if (edge_evt) ctrl_next[CIS_INTF_BIT] = 1'b1;
		if (ext_sync[1]) ctrl_next[CIS_RBIF_BIT] = 1'b1;
		pflag_next = pflag_next | periph_evt;
		case (state_reg)
			CIS_FETCH: begin
				if (irq_pending) begin
					// One dead cycle so the vector arrives four or five cycles after the pin, one more from CIS_SECOND or CIS_HALT.
					state_next = CIS_IRQ_SYNC;
				end else if (instr_valid) begin
					pc_next = pc_reg + 13'd1;
					if (instr_word == CIS_OPC_RETURN) begin
						pop_next = 1'b1;
						state_next = CIS_SECOND;
					end else if (instr_word == CIS_OPC_RETURN_FROM_IRQ_OP) begin
						pop_next = 1'b1;
						ctrl_next[CIS_GIE_BIT] = 1'b1;
						state_next = CIS_SECOND;
					end else if (instr_word == CIS_OPC_WATCHDOG_CLEAR_OP) begin
						wdc_next = 1'b1;
						to_next = 1'b1;
						pd_next = 1'b1;
					end else if (instr_word == CIS_OPC_SLEEP) begin
						wdc_next = 1'b1;
						to_next = 1'b1;
						pd_next = 1'b0;
						state_next = CIS_HALT;
					end else if (instr_word[13:11] == CIS_OPH_CALL) begin
						push_next = 1'b1;
						pdata_next = pc_reg + 13'd1;
						call_tgt_next = {pc_high_latch[CIS_LATCH_HI:CIS_LATCH_LO], instr_word[10:0]};
						state_next = CIS_SECOND;
					end else if (instr_word[13:7] == CIS_OPH_CLR) begin
						// Every operand, 0 included, names a file register, so indirect clears still land.
						fdata_next = CIS_ZERO8;
						fwe_next = 1'b1;
						z_next = 1'b1;
						zwe_next = 1'b1;
					end else if (instr_word[13:7] == {CIS_OPH_CLR[6:1], 1'b0} && instr_word[7] == 1'b0) begin
						w_next = CIS_ZERO8;
						z_next = 1'b1;
						zwe_next = 1'b1;
					end else if (instr_word[13:8] == CIS_OPH_FILE_INVERT_OP || instr_word[13:8] == CIS_OPH_FILE_DECREMENT_OP) begin
						res = (instr_word[13:8] == CIS_OPH_FILE_INVERT_OP) ? ~file_rdata : file_rdata - CIS_ONE8;
						z_next = (res == CIS_ZERO8);
						zwe_next = 1'b1;
						if (dest_file) begin
							fdata_next = res;
							fwe_next = 1'b1;
						end else begin
							w_next = res;
						end
					end else if (instr_word[13:8] == CIS_OPH_RLF || instr_word[13:8] == CIS_OPH_RRF) begin
						if (instr_word[13:8] == CIS_OPH_RLF) begin
							res = {file_rdata[6:0], c_reg};
							c_next = file_rdata[7];
						end else begin
							res = {c_reg, file_rdata[7:1]};
							c_next = file_rdata[0];
						end
						cwe_next = 1'b1;
						if (dest_file) begin
							fdata_next = res;
							fwe_next = 1'b1;
						end else begin
							w_next = res;
						end
					end
				end
			end
			CIS_SECOND: begin
				// Second cycle of call and returns loads the new program counter.
				pc_next = pop_reg ? stack_top : call_tgt_reg;
				state_next = CIS_FETCH;
			end
			CIS_IRQ_SYNC: begin
				ctrl_next[CIS_GIE_BIT] = 1'b0;
				push_next = 1'b1;
				pdata_next = pc_reg;
				pc_next = CIS_IRQ_VECTOR;
				state_next = CIS_FETCH;
			end
			CIS_HALT: begin
				// Halted in CIS_HALT; the wake line or a request with the global enable set resumes.
				if (wake_evt || irq_pending) begin
					state_next = CIS_FETCH;
				end
			end
			default: state_next = CIS_FETCH;
		endcase
	end

	// State registers; reset leaves the global enable clear.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CIS_CTRL_RESET;
			pflag_reg <= '0;
			pen_reg <= '0;
			state_reg <= CIS_FETCH;
			pc_reg <= CIS_RESET_VECTOR;
			call_tgt_reg <= CIS_RESET_VECTOR;
			w_reg <= CIS_ZERO8;
			z_reg <= 1'b0;
			c_reg <= 1'b0;
			to_reg <= 1'b1;
			pd_reg <= 1'b1;
			fdata_reg <= CIS_ZERO8;
			faddr_reg <= '0;
			fwe_reg <= 1'b0;
			zwe_reg <= 1'b0;
			cwe_reg <= 1'b0;
			push_reg <= 1'b0;
			pop_reg <= 1'b0;
			wdc_reg <= 1'b0;
			pdata_reg <= CIS_RESET_VECTOR;
		end else begin
			ctrl_reg <= ctrl_next;
			pflag_reg <= pflag_next;
			pen_reg <= pen_next;
			state_reg <= state_next;
			pc_reg <= pc_next;
			call_tgt_reg <= call_tgt_next;
			w_reg <= w_next;
			z_reg <= z_next;
			c_reg <= c_next;
			to_reg <= to_next;
			pd_reg <= pd_next;
			fdata_reg <= fdata_next;
			faddr_reg <= faddr_next;
			fwe_reg <= fwe_next;
			zwe_reg <= zwe_next;
			cwe_reg <= cwe_next;
			push_reg <= push_next;
			pop_reg <= pop_next;
			wdc_reg <= wdc_next;
			pdata_reg <= pdata_next;
		end
	end

	// Outputs come straight from registers except the fetch handshake and the asleep decode.
	assign fetch_req = (state_reg == CIS_FETCH) & ~irq_pending;
	assign pc = pc_reg;
	assign file_addr = faddr_reg;
	assign file_we = fwe_reg;
	assign file_wdata = fdata_reg;
	assign stack_push = push_reg;
	assign stack_pop = pop_reg;
	assign stack_push_data = pdata_reg;
	assign w_reg_out = w_reg;
	assign zero_flag = z_reg;
	assign carry_flag = c_reg;
	assign zero_we = zwe_reg;
	assign carry_we = cwe_reg;
	assign timeout_status = to_reg;
	assign powerdown_status = pd_reg;
	assign watchdog_clear = wdc_reg;
	assign asleep = (state_reg == CIS_HALT);
	assign irq_control_reg = ctrl_reg;
	assign periph_flags = pflag_reg;
	assign periph_enables = pen_reg;
	// carry_in is reserved for an external status source; the core keeps its own carry.
	logic unused_carry;
	assign unused_carry = carry_in;
endmodule // cis_core

// [verification/cis_core_assertions.sv]
`timescale 1ns/1ps
// Port-level checks on the core, bound into every instance of it.
module cis_core_assertions
	import cis_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] pc_high_latch,
	input wire logic edge_irq_pin,
	input wire logic [10:0] periph_evt,
	input wire logic [12:0] pc,
	input wire logic fetch_req,
	input wire logic [6:0] file_addr,
	input wire logic file_we,
	input wire logic [7:0] file_wdata,
	input wire logic stack_push,
	input wire logic stack_pop,
	input wire logic [12:0] stack_push_data,
	input wire logic [7:0] w_reg_out,
	input wire logic zero_flag,
	input wire logic carry_flag,
	input wire logic zero_we,
	input wire logic carry_we,
	input wire logic timeout_status,
	input wire logic powerdown_status,
	input wire logic watchdog_clear,
	input wire logic asleep,
	input wire logic [7:0] irq_control_reg,
	input wire logic [10:0] periph_flags,
	input wire logic [10:0] periph_enables
);
	// Named slices, so that the sampled-value functions see plain signals.
	wire take = fetch_req && instr_valid;
	wire [5:0] opc = instr_word[13:8];
	wire [1:0] hi = pc_high_latch[4:3];
	wire [10:0] lo = instr_word[10:0];
	wire [6:0] fa = instr_word[6:0];
	wire rd7 = file_rdata[7];
	wire rd0 = file_rdata[0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// A request is live only with the global enable and every enable on its path set.
	sequence s_pend;
		irq_control_reg[7] && ((|(irq_control_reg[5:3] & irq_control_reg[2:0]))
			|| (irq_control_reg[6] && (|(periph_flags & periph_enables))));
	endsequence
	sequence s_vec;
		pc == CIS_IRQ_VECTOR && !irq_control_reg[7];
	endsequence
	gie_reset_a: assert property ($fell(rst) |-> !irq_control_reg[7]) else $error("enable set after reset");
	irq_take_a: assert property (s_pend |-> ##[1:3] s_vec) else $error("request not vectored");
	pin_latency_a: assert property ($rose(edge_irq_pin) && irq_control_reg[7] && irq_control_reg[4]
		&& fetch_req |-> ##[3:6] s_vec) else $error("pin request too slow");
	flag_set_a: assert property (periph_evt != 11'h000 |=>
		(periph_flags & $past(periph_evt)) == $past(periph_evt)) else $error("flag not set");
	return_from_irq_op_a: assert property (take && instr_word == CIS_OPC_RETURN_FROM_IRQ_OP |=>
		stack_pop ##[1:2] irq_control_reg[7]) else $error("irq return wrong");
	call_a: assert property (take && instr_word[13:11] == CIS_OPH_CALL |=> stack_push
		&& stack_push_data == $past(pc) + 13'h0001 ##1 pc == {$past(hi, 2), $past(lo, 2)})
		else $error("call wrong");
	return_a: assert property (take && instr_word == CIS_OPC_RETURN |=>
		stack_pop && !zero_we && !carry_we ##1 !zero_we && !carry_we) else $error("return wrong");
	clear_a: assert property (take && instr_word[13:7] == CIS_OPH_CLR |=> file_we
		&& file_wdata == CIS_ZERO8 && file_addr == $past(fa) && zero_flag) else $error("file clear wrong");
	accumulator_clear_op_a: assert property (take && instr_word[13:7] == 7'h02 |=>
		!file_we && w_reg_out == CIS_ZERO8 && zero_flag) else $error("acc clear wrong");
	rlf_a: assert property (take && opc == CIS_OPH_RLF |=>
		carry_we && !zero_we && carry_flag == $past(rd7)) else $error("left carry wrong");
	rrf_a: assert property (take && opc == CIS_OPH_RRF |=>
		carry_we && !zero_we && carry_flag == $past(rd0)) else $error("right carry wrong");
	wdt_a: assert property (take && instr_word == CIS_OPC_WATCHDOG_CLEAR_OP |=>
		watchdog_clear && timeout_status && powerdown_status) else $error("watchdog clear wrong");
	sleep_a: assert property (take && instr_word == CIS_OPC_SLEEP |=>
		watchdog_clear && timeout_status && !powerdown_status && asleep) else $error("sleep wrong");
endmodule // cis_core_assertions

bind cis_core cis_core_assertions u_chk (.*);

// [verification/cis_src_model.sv]
`timescale 1ns/1ps
// Interrupt sources: code 1 pin, 2 port change, 3 timer, 4 to 14 one peripheral each.
module cis_src_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] fire,
	output logic edge_irq_pin,
	output logic port_change_evt,
	output logic timer_zero_ovf,
	output logic [10:0] periph_evt
);
	logic [2:0] hold;
	// The pin is held for several cycles so that the synchroniser cannot miss it.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hold <= 3'h0;
			port_change_evt <= 1'h0;
			timer_zero_ovf <= 1'h0;
			periph_evt <= 11'h000;
		end else begin
			hold <= (fire == 4'h1) ? 3'h5 : (hold != 3'h0) ? hold - 3'h1 : 3'h0;
			port_change_evt <= (fire == 4'h2);
			timer_zero_ovf <= (fire == 4'h3);
			periph_evt <= (fire > 4'h3) ? 11'h001 << (fire - 4'h4) : 11'h000;
		end
	end
	assign edge_irq_pin = (hold != 3'h0);
endmodule // cis_src_model

// [verification/test_cis_core.sv]
`timescale 1ns/1ps
module test_cis_core
	import cis_pkg::*;
;
	logic sys_clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, carry_in = 1'h0, wake_evt = 1'h0;
	logic ctrl_we = 1'h0, periph_enable_we = 1'h0, z_t = 1'h0, c_t = 1'h0, d;
	logic [13:0] instr_word = 14'h0000;
	logic [7:0] file_rdata = 8'h00, pc_high_latch = 8'h00, ctrl_wdata = 8'h00, w_t = 8'h00, rd, r, lat;
	logic [12:0] stack_top = 13'h0000, pc, stack_push_data, pc_t, t1;
	logic [10:0] periph_flag_clr = 11'h000, periph_enable_wdata = 11'h000, periph_flags, periph_enables, periph_evt, k;
	logic [3:0] fire = 4'h0;
	logic [6:0] f, file_addr;
	logic [7:0] file_wdata, w_reg_out, irq_control_reg;
	logic fetch_req, file_we, stack_push, stack_pop, zero_flag, carry_flag, zero_we, carry_we, timeout_status;
	logic powerdown_status, watchdog_clear, asleep, edge_irq_pin, port_change_evt, timer_zero_ovf;
	logic [18:0] rq[$];
	logic [12:0] sq[$];
	int err_total = 0, n_tests = 0, cyc = 0, i;
	cis_core u_dut (.*);
	cis_src_model u_src (.*);
	always #5 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// Present one instruction and hold it until an edge where the core fetches.
	task automatic op(input logic [13:0] w, input logic [7:0] v);
		logic t;
		t = 1'h0;
		@(posedge sys_clk);
		instr_word <= w;
		file_rdata <= v;
		instr_valid <= 1'h1;
		while (!t) begin
			@(negedge sys_clk);
			t = (fetch_req === 1'h1);
			@(posedge sys_clk);
		end
		instr_valid <= 1'h0;
	endtask
	// Note the result of a file operation; a d of zero lands in the working register.
	task automatic put(input logic dd, input logic [7:0] v);
		if (!dd) w_t = v;
		rq.push_back({dd, dd ? v : 8'h00, w_t, z_t, c_t});
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic creg(input logic [7:0] v);
		@(posedge sys_clk);
		ctrl_we <= 1'h1;
		ctrl_wdata <= v;
		@(posedge sys_clk);
		ctrl_we <= 1'h0;
	endtask
	task automatic pen(input logic [10:0] v);
		@(posedge sys_clk);
		periph_enable_we <= 1'h1;
		periph_enable_wdata <= v;
		@(posedge sys_clk);
		periph_enable_we <= 1'h0;
	endtask
	task automatic pclr(input logic [10:0] v);
		@(posedge sys_clk);
		periph_flag_clr <= v;
		@(posedge sys_clk);
		periph_flag_clr <= 11'h000;
	endtask
	task automatic fz(input logic [3:0] v);
		@(posedge sys_clk);
		fire <= v;
		@(posedge sys_clk);
		fire <= 4'h0;
	endtask
	// Results are compared in arrival order, so a missing or extra pulse shows up.
	always @(posedge sys_clk) begin
		#1;
		if (file_we === 1'h1 || zero_we === 1'h1 || carry_we === 1'h1)
			chk({file_we, file_we ? file_wdata : 8'h00, w_reg_out, zero_flag, carry_flag}, rq.pop_front());
		if (stack_push === 1'h1) chk(stack_push_data, sq.pop_front());
	end
	// Cut a hang short.
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		void'($urandom(81));
		repeat (8) @(posedge sys_clk);
		rst <= 1'h0;
		lat = 8'($urandom);
		pc_high_latch <= lat;
		k = 11'($urandom);
		sq.push_back(13'h0001);
		op({CIS_OPH_CALL, k}, 8'h00);
		wt(2);
		t1 = {lat[4:3], k};
		chk(pc, t1);
		sq.push_back(t1 + 13'h0001);
		op({CIS_OPH_CALL, ~k}, 8'h00);
		wt(2);
		chk(pc, {lat[4:3], ~k});
		stack_top <= t1 + 13'h0001;
		op(CIS_OPC_RETURN, 8'h00);
		wt(3);
		pc_t = t1 + 13'h0001;
		chk(pc, pc_t);
		// File operations; the first pass drives the zero-result boundary.
		for (i = 0; i < 8; i++) begin
			rd = (i == 0) ? 8'hFF : 8'($urandom);
			d = i[0];
			f = 7'($urandom);
			z_t = (rd == 8'hFF);
			put(d, ~rd);
			op({CIS_OPH_FILE_INVERT_OP, d, f}, rd);
			put(d, rd + 8'h01);
			op({CIS_OPH_FILE_DECREMENT_OP, d, f}, rd + 8'h02);
			r = {rd[6:0], c_t};
			c_t = rd[7];
			put(d, r);
			op({CIS_OPH_RLF, d, f}, rd);
			r = {c_t, rd[7:1]};
			c_t = rd[0];
			put(d, r);
			op({CIS_OPH_RRF, d, f}, rd);
			z_t = 1'h1;
			put(1'h1, 8'h00);
			op({CIS_OPH_CLR, f}, rd);
			put(1'h0, 8'h00);
			op(14'h0100, rd);
			pc_t = pc_t + 13'h0006;
		end
		// Flags set while masked, and nothing is taken.
		pen(11'h7FF);
		creg(8'h80);
		fz(4'h4);
		wt(8);
		chk({pc, periph_flags[0], periph_enables}, {pc_t, 1'h1, 11'h7FF});
		creg(8'h10);
		fz(4'h1);
		wt(8);
		chk({pc, irq_control_reg}, {pc_t, 8'h12});
		creg(8'h00);
		pclr(11'h7FF);
		wt(1);
		chk(periph_flags, 11'h000);
		// Each of the fourteen sources is taken, serviced and returned from.
		for (i = 0; i < 14; i++) begin
			if (i < 3) creg(i == 0 ? 8'h90 : i == 1 ? 8'h88 : 8'hA0);
			else begin
				pen(11'h001 << (i - 3));
				creg(8'hC0);
			end
			sq.push_back(pc_t);
			fz(4'(i + 1));
			for (int n = 0; n < 20 && pc !== CIS_IRQ_VECTOR; n++) wt(1);
			chk({pc, irq_control_reg[7]}, {CIS_IRQ_VECTOR, 1'h0});
			creg(8'h00);
			pclr(11'h7FF);
			stack_top <= pc_t;
			op(CIS_OPC_RETURN_FROM_IRQ_OP, 8'h00);
			wt(3);
			chk({pc, irq_control_reg[7]}, {pc_t, 1'h1});
		end
		op(CIS_OPC_SLEEP, 8'h00);
		wt(0);
		chk({watchdog_clear, asleep, timeout_status, powerdown_status}, 4'hE);
		@(posedge sys_clk);
		wake_evt <= 1'h1;
		@(posedge sys_clk);
		wake_evt <= 1'h0;
		wt(2);
		chk(asleep, 1'h0);
		op(CIS_OPC_WATCHDOG_CLEAR_OP, 8'h00);
		wt(0);
		chk({watchdog_clear, timeout_status, powerdown_status}, 3'h7);
		wt(2);
		chk(32'(rq.size() + sq.size()), 32'h0);
		test_done();
	end
endmodule // test_cis_core
